//--- cbbc_consts.svh
// constants for the carry branch / bit clear execution block
// assumes: included by the package user and the top module
`ifndef CBBC_CONSTS_SVH
`define CBBC_CONSTS_SVH
`define CBBC_OP_BRANCH_HI   8'hE2
`define CBBC_OP_BITCLR      4'h9
`define CBBC_PC_WIDTH       21
`define CBBC_ADDR_WIDTH     12
`define CBBC_PC_STEP        21'h000002
`define CBBC_ACCESS_SPLIT   8'h60
`define CBBC_ACCESS_HI_BANK 4'hF
`define CBBC_BIT_POS_LSB    9
`define CBBC_BANK_FLAG_POS  8
`define CBBC_PC_RESET       21'h000000
`endif

//--- cbbc_pkg.sv
// types for the carry branch / bit clear execution block
// assumes: cbbc_consts.svh is on the include path
`include "cbbc_consts.svh"
package cbbc_pkg;
   typedef enum logic [2:0] {
      CBBC_EXEC  = 3'h1,
      CBBC_STALL = 3'h2,
      CBBC_IDLE  = 3'h4
   } cbbc_state_e;
   // data memory write request
   typedef struct packed {
      logic                         wr;
      logic [`CBBC_ADDR_WIDTH-1:0] addr;
      logic [7:0]                   data;
   } cbbc_dwr_s;
   // fetch stage handoff
   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } cbbc_instr_s;
endpackage

//--- cbbc_exec.sv
// execution of the carry branch and the register bit clear instructions
// assumes: one clk_in edge per instruction cycle (Q1..Q4 folded into it);
// the fetch stage offers one word at a time and holds off while stall_out is high
// Notes on behaviour
// - branch: one word, one cycle, two if taken
// - taken: decode, read, process, write pc; then nop
// - taken target is address plus two plus 2n
// - clear only the indexed bit, keep others
// - bank flag zero uses access bank
// - bank flag one uses bank select register
// - branch only when carry equals one
// - offset signed, doubled, added to incremented pc
`include "cbbc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cbbc_exec (
   // clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   // fetch stage
   input  wire cbbc_pkg::cbbc_instr_s         instr_in,
   input  wire logic [`CBBC_PC_WIDTH-1:0]     instr_addr_in,
   input  wire logic                          carry_in,
   input  wire logic [3:0]                    bank_select_register_in,
   // data memory read port, combinational answer for the decoded address
   output logic [`CBBC_ADDR_WIDTH-1:0]        rd_addr_out,
   input  wire logic [7:0]                    rd_data_in,
   // results
   output var cbbc_pkg::cbbc_dwr_s            dwr_out,
   output logic [`CBBC_PC_WIDTH-1:0]          program_counter_out,
   output logic                               pc_load_out,
   output logic                               stall_out,
   output logic                               status_write_out
);
   import cbbc_pkg::*;

   // ==========================================================
   // decode
   logic                          is_branch;
   logic                          is_clear;
   logic                          take;
   logic [2:0]                    bit_idx;
   logic                          bank_flag;
   logic [7:0]                    reg_field;
   logic [`CBBC_ADDR_WIDTH-1:0]   data_addr;
   logic [`CBBC_PC_WIDTH-1:0]     target;
   logic [`CBBC_PC_WIDTH-1:0]     next_seq;
   logic [`CBBC_PC_WIDTH-1:0]     offset_x2;
   logic [7:0]                    cleared;
   cbbc_state_e                   state_reg;
   cbbc_state_e                   state_next;
   logic                          ready;

   assign ready     = (state_reg == CBBC_EXEC);
   assign is_branch = ready && instr_in.valid && (instr_in.word[15:8] == `CBBC_OP_BRANCH_HI);
   assign is_clear  = ready && instr_in.valid && (instr_in.word[15:12] == `CBBC_OP_BITCLR);
   assign take      = is_branch && carry_in;
   assign bit_idx   = instr_in.word[`CBBC_BIT_POS_LSB+2:`CBBC_BIT_POS_LSB];
   assign bank_flag = instr_in.word[`CBBC_BANK_FLAG_POS];
   assign reg_field = instr_in.word[7:0];

   // access bank splits low page and the top bank; bank select is used only when the bank flag is one
   always_comb begin
      if (!bank_flag) begin
         if (reg_field < `CBBC_ACCESS_SPLIT) begin
            data_addr = {4'h0, reg_field};
         end else begin
            data_addr = {`CBBC_ACCESS_HI_BANK, reg_field};
         end
      end else begin
         data_addr = {bank_select_register_in, reg_field};
      end
   end

   // offset is sign extended then doubled; the base is the already stepped pc
   assign next_seq  = instr_addr_in + `CBBC_PC_STEP;
   assign offset_x2 = {{(`CBBC_PC_WIDTH-9){instr_in.word[7]}}, instr_in.word[7:0], 1'b0};
   assign target    = next_seq + offset_x2;

   assign cleared = rd_data_in & ~(8'h01 << bit_idx);
   assign rd_addr_out = data_addr;

   // ==========================================================
   // sequencing
   // idle makes the first instruction wait one edge after reset and is also where any illegal state code recovers to
   always_comb begin
      case (state_reg)
         CBBC_IDLE:  state_next = CBBC_EXEC;
         CBBC_EXEC:  state_next = take ? CBBC_STALL : CBBC_EXEC;
         CBBC_STALL: state_next = CBBC_EXEC;
         default:    state_next = CBBC_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= CBBC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // stall flags the nop cycle of a taken branch
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stall_out <= 1'b0;
      end else begin
         stall_out <= take;
      end
   end

   // ==========================================================
   // program counter load
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         program_counter_out <= `CBBC_PC_RESET;
         pc_load_out         <= 1'b0;
      end else begin
         pc_load_out <= take;
         if (take) begin
            program_counter_out <= target;
         end
      end
   end

   // ==========================================================
   // data write
   // read and modify share the decode cycle, the write reaches memory two edges later,
   // so a clear right behind another clear of the same register would read stale data
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dwr_out <= '0;
      end else begin
         dwr_out.wr   <= is_clear;
         dwr_out.addr <= data_addr;
         dwr_out.data <= cleared;
      end
   end

   // ==========================================================
   // status; neither instruction here changes a flag
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status_write_out <= 1'b0;
      end else begin
         status_write_out <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   // branch path
   a_taken_loads_pc: assert property (@(posedge clk_in) disable iff (rst_in)
      take |=> pc_load_out && program_counter_out == $past(target))
      else $error("pc not loaded");
   a_untaken_no_load: assert property (@(posedge clk_in) disable iff (rst_in)
      (is_branch && !carry_in) |=> !pc_load_out && !stall_out)
      else $error("untaken branch loaded");
   a_nop_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
      take |=> stall_out ##1 (state_reg == CBBC_EXEC))
      else $error("no single nop cycle");
   a_two_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
      take |=> !ready ##1 ready)
      else $error("taken branch not two cycles");
   a_offset_double: assert property (@(posedge clk_in) disable iff (rst_in)
      take |=> program_counter_out[0] == $past(instr_addr_in[0]))
      else $error("offset not doubled");
   a_load_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      pc_load_out |=> !pc_load_out)
      else $error("pc load longer than one cycle");
   a_stall_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      stall_out |=> !stall_out)
      else $error("nop cycle longer than one cycle");
   a_stall_refuses: assert property (@(posedge clk_in) disable iff (rst_in)
      stall_out |=> !pc_load_out && !dwr_out.wr)
      else $error("work accepted in nop cycle");
   a_pc_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      !take |=> $stable(program_counter_out))
      else $error("pc moved without taken branch");
   // bit clear path
   a_clear_bit: assert property (@(posedge clk_in) disable iff (rst_in)
      is_clear |=> dwr_out.wr && dwr_out.data == ($past(rd_data_in) & ~(8'h01 << $past(bit_idx))))
      else $error("bit clear value wrong");
   a_clear_target: assert property (@(posedge clk_in) disable iff (rst_in)
      is_clear |=> !dwr_out.data[$past(bit_idx)])
      else $error("selected bit not cleared");
   a_clear_others: assert property (@(posedge clk_in) disable iff (rst_in)
      is_clear |=> (dwr_out.data | (8'h01 << $past(bit_idx))) == ($past(rd_data_in) | (8'h01 << $past(bit_idx))))
      else $error("other bits changed");
   a_access_bank: assert property (@(posedge clk_in) disable iff (rst_in)
      (is_clear && !bank_flag) |=> dwr_out.addr[11:8] == 4'h0 || dwr_out.addr[11:8] == 4'hF)
      else $error("access bank not used");
   a_access_low: assert property (@(posedge clk_in) disable iff (rst_in)
      (is_clear && !bank_flag && reg_field < `CBBC_ACCESS_SPLIT)
      |=> dwr_out.addr == {4'h0, $past(reg_field)})
      else $error("access bank low page wrong");
   a_access_high: assert property (@(posedge clk_in) disable iff (rst_in)
      (is_clear && !bank_flag && reg_field >= `CBBC_ACCESS_SPLIT)
      |=> dwr_out.addr == {`CBBC_ACCESS_HI_BANK, $past(reg_field)})
      else $error("access bank high page wrong");
   a_bank_select: assert property (@(posedge clk_in) disable iff (rst_in)
      (is_clear && bank_flag) |=> dwr_out.addr == {$past(bank_select_register_in), $past(reg_field)})
      else $error("bank select not used");
   a_no_status: assert property (@(posedge clk_in) disable iff (rst_in)
      is_clear |=> !status_write_out && !pc_load_out)
      else $error("clear touched status");
   a_write_only_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      !is_clear |=> !dwr_out.wr)
      else $error("write without bit clear");
   // reset and status
   a_status_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      !status_write_out)
      else $error("status write raised");
   a_reset_quiet: assert property (@(posedge clk_in)
      rst_in |=> !pc_load_out && !stall_out && !dwr_out.wr && !status_write_out)
      else $error("outputs active after reset");
   c_taken: cover property (@(posedge clk_in) disable iff (rst_in) take);
   c_nop_cycle: cover property (@(posedge clk_in) disable iff (rst_in) stall_out);
   c_untaken: cover property (@(posedge clk_in) disable iff (rst_in) is_branch && !carry_in);
   c_clear_banked: cover property (@(posedge clk_in) disable iff (rst_in) is_clear && bank_flag);
   c_clear_access: cover property (@(posedge clk_in) disable iff (rst_in) is_clear && !bank_flag);
endmodule
`default_nettype wire

//--- cbbc_dmem.sv
// data memory model facing the bit clear path
// assumes: combinational read port, write on the one-cycle wr pulse
`timescale 1ns/1ps
`default_nettype none
module cbbc_dmem
   import cbbc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic [11:0] rd_addr_in,
   input  wire cbbc_dwr_s   dwr_in,
   output logic [7:0]       rd_data_out
);
   logic [7:0] mem [0:4095];
   // contents derived from the low address byte, so a wrong low byte reads a wrong value
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hC7;
   end
   assign rd_data_out = mem[rd_addr_in];
   always @(posedge clk_in) begin
      if (dwr_in.wr) begin
         mem[dwr_in.addr] <= dwr_in.data;
      end
   end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the carry branch / bit clear block
// assumes: cbbc_pkg and cbbc_dmem compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cbbc_pkg::*;
   logic        clk_in, rst_in, carry_in, pc_load_out, stall_out, status_write_out;
   cbbc_instr_s instr_in;
   logic [20:0] instr_addr_in, program_counter_out;
   logic [3:0]  bank_select_register_in;
   logic [11:0] rd_addr_out;
   logic [7:0]  rd_data_in;
   cbbc_dwr_s   dwr_out;
   int          bad_count, cmp_count;
   cbbc_exec uut (.clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in), .instr_addr_in(instr_addr_in),
      .carry_in(carry_in), .bank_select_register_in(bank_select_register_in), .rd_addr_out(rd_addr_out),
      .rd_data_in(rd_data_in), .dwr_out(dwr_out), .program_counter_out(program_counter_out),
      .pc_load_out(pc_load_out), .stall_out(stall_out), .status_write_out(status_write_out));
   cbbc_dmem dmem (.clk_in(clk_in), .rd_addr_in(rd_addr_out), .dwr_in(dwr_out), .rd_data_out(rd_data_in));
   // ====
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one word for one cycle; outputs sampled after the answering edge
   task automatic issue(input logic [15:0] w, input logic c, input logic [3:0] b);
      @(posedge clk_in);
      instr_in <= {1'b1, w};
      carry_in <= c;
      bank_select_register_in <= b;
      @(posedge clk_in);
      instr_in <= '0;
      #1;
   endtask
   task automatic branch(input logic [7:0] n, input logic c);
      issue({8'hE2, n}, c, 4'h0);
      check(pc_load_out, c);
      check(stall_out, c);
      if (c) check(program_counter_out, 21'(instr_addr_in + 21'h2 + {{12{n[7]}}, n, 1'b0}));
      @(posedge clk_in);
      #1;
      check({pc_load_out, stall_out, status_write_out}, 0);
   endtask
   task automatic branch_cases;
      branch(8'hFB, 1'b1);
      branch(8'h7F, 1'b1);
      branch(8'h80, 1'b1);
      branch(8'h05, 1'b0);
   endtask
   task automatic clear_bit(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [3:0] bs,
                            input logic [11:0] ea);
      issue({4'h9, b, a, f}, 1'b1, bs);
      check(dwr_out.wr, 1);
      check(dwr_out.addr, ea);
      check(dwr_out.data, (ea[7:0] ^ 8'hC7) & ~(8'h01 << b));
      check({status_write_out, pc_load_out}, 0);
   endtask
   task automatic clear_cases;
      clear_bit(3'h7, 1'b0, 8'h10, 4'h5, 12'h010);
      clear_bit(3'h0, 1'b0, 8'hA3, 4'h5, 12'hFA3);
      clear_bit(3'h3, 1'b1, 8'h42, 4'h5, 12'h542);
      // unknown opcode must leave everything quiet; the read address still follows the word
      @(posedge clk_in);
      instr_in <= {1'b1, 16'h1234};
      #1;
      check(rd_addr_out, 12'h034);
      @(posedge clk_in);
      instr_in <= '0;
      #1;
      check({dwr_out.wr, pc_load_out, stall_out}, 0);
   endtask
   // ====
   // run
   initial begin
      clk_in = 0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
   initial begin
      rst_in = 1;
      instr_in = '0;
      carry_in = 0;
      bank_select_register_in = 0;
      instr_addr_in = 21'h000100;
      repeat (3) @(posedge clk_in);
      rst_in <= 0;
      #1;
      check({pc_load_out, stall_out, dwr_out.wr}, 0);
      branch_cases();
      clear_cases();
      close_out();
   end
endmodule
`default_nettype wire
